// >>> logic/mpc_pkg.sv
// constants of the four-channel pwm controller: map, field positions, reset values
// assumes a 32-bit word bus where each register takes one aligned word
package mpc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam int unsigned AW          = 10;
  localparam logic [9:0]  OFS_MODE    = 10'h000;
  localparam logic [9:0]  OFS_START   = 10'h004;
  localparam logic [9:0]  OFS_STOP    = 10'h008;
  localparam logic [9:0]  OFS_RUN     = 10'h00C;
  localparam logic [9:0]  OFS_IRQ_SET = 10'h010;
  localparam logic [9:0]  OFS_IRQ_CLR = 10'h014;
  localparam logic [9:0]  OFS_MASK    = 10'h018;
  localparam logic [9:0]  OFS_FLAGS   = 10'h01C;
  localparam logic [2:0]  CH_REGION   = 3'h4;
  localparam logic [4:0]  OFS_CFG     = 5'h00;
  localparam logic [4:0]  OFS_DUTY    = 5'h04;
  localparam logic [4:0]  OFS_PERIOD  = 5'h08;
  localparam logic [4:0]  OFS_COUNT   = 5'h0C;
  localparam logic [4:0]  OFS_UPDATE  = 5'h10;

  // ----------------------------------------------------------------
  // field positions and codes
  // ----------------------------------------------------------------
  localparam int unsigned DIV1_LSB    = 0;
  localparam int unsigned PRE1_LSB    = 8;
  localparam int unsigned DIV2_LSB    = 16;
  localparam int unsigned PRE2_LSB    = 24;
  localparam int unsigned ALIGN_BIT   = 8;
  localparam int unsigned POL_BIT     = 9;
  localparam int unsigned UPD_BIT     = 10;
  localparam int unsigned PRESCALE_W  = 10;
  localparam logic [3:0]  PRE_MAX     = 4'hA;
  localparam logic [3:0]  PRE_DIV1    = 4'hB;
  localparam logic [3:0]  PRE_DIV2    = 4'hC;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;

endpackage

// >>> logic/mpc_top.sv
// four-channel pwm controller with an ahb-lite register slave
// assumes a single ahb-lite master, word transfers, hready tied to hreadyout
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - run status register shows one bit per channel, set while output runs
// - writing one to irq enable register sets that channel's mask bit
// - writing one to irq disable register clears that channel's mask bit
// - mask view register returns the mask bit of every channel
// - a channel's event flag sets whenever one of its periods completes
// - reading the event flag register clears all flags except one set by a period end in the same cycle
// - clock select picks master clock over 1..1024, or divided clock one or two
// - config bit 8 chooses left aligned when clear, centre aligned when set
// - config bit 9 gives the level each period starts with
// - config bit 10 steers the update register to duty or to period
// - duty, period and counter hold only sixteen significant bits
// - left aligned period equals period value times the clock divisor
// - centre aligned period equals twice period value times the divisor
// - enabling a channel clears its counter
// - left aligned counter wraps at the period value and is readable
// - on a running channel the update value waits for the end of period, then loads; a stopped channel loads it at once
// - divider factor zero stops, one passes, 2 to 255 divide the clock
// - start register ones start channels, stop register ones stop them
module mpc_top #(
  parameter int unsigned NCH = 4,
  parameter int unsigned CW  = 16
) (
  // clock and reset
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // ahb-lite slave
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  // waveform outputs
  output logic [NCH-1:0]       pwm_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  rdy;
    logic                  err;
    logic                  pend;
    logic                  pwr;
    logic [9:0]            paddr;
    logic [31:0]           rdata;
    logic [31:0]           mode;
    logic [9:0]            pcnt;
    logic [7:0]            acnt;
    logic [7:0]            bcnt;
    logic [NCH-1:0]        run;
    logic [NCH-1:0]        mask;
    logic [NCH-1:0]        flag;
    logic [NCH-1:0]        pwm;
    logic [NCH-1:0]        dir;
    logic [NCH-1:0]        upd_v;
    logic [NCH-1:0][10:0]  cfg;
    logic [NCH-1:0][CW-1:0] dty;
    logic [NCH-1:0][CW-1:0] prd;
    logic [NCH-1:0][CW-1:0] cnt;
    logic [NCH-1:0][CW-1:0] upd;
  } mpc_state_t;

  mpc_state_t s;
  mpc_state_t next_s;

  logic           acc;
  logic           wr_go;
  logic           rd_flags;
  logic           tick_a;
  logic           tick_b;
  logic [NCH-1:0] tick;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // power-of-two taps of one free counter keep all channels phase aligned
  function automatic logic pre_tick(input logic [3:0] code, input logic [9:0] c,
                                    input logic ta, input logic tb);
    logic [10:0] m;
    m = (11'h001 << code) - 11'h001;
    if (code <= mpc_pkg::PRE_MAX) return &(c | ~m[9:0]);
    if (code == mpc_pkg::PRE_DIV1) return ta;
    if (code == mpc_pkg::PRE_DIV2) return tb;
    return 1'b0;
  endfunction

  function automatic logic is_ch(input logic [9:0] a);
    return a[9:7] == mpc_pkg::CH_REGION && a[1:0] == 2'h0 && 32'(a[6:5]) < NCH;
  endfunction

  function automatic logic div_tick(input logic [7:0] f, input logic [7:0] c, input logic src);
    if (f == 8'h00) return 1'b0;
    if (f == 8'h01) return src;
    return src && c == f - 8'h01;
  endfunction

  function automatic logic [7:0] div_next(input logic [7:0] f, input logic [7:0] c,
                                          input logic src);
    if (f <= 8'h01 || !src) return c;
    return (c == f - 8'h01) ? 8'h00 : c + 8'h01;
  endfunction

  assign acc      = hsel && hready && htrans[1];
  assign wr_go    = s.pend && s.pwr;
  assign rd_flags = acc && !hwrite && haddr[9:0] == mpc_pkg::OFS_FLAGS;

  // ----------------------------------------------------------------
  // clock dividers
  // ----------------------------------------------------------------
  assign tick_a = div_tick(s.mode[mpc_pkg::DIV1_LSB +: 8], s.acnt,
                           pre_tick(s.mode[mpc_pkg::PRE1_LSB +: 4], s.pcnt, 1'b0, 1'b0));
  assign tick_b = div_tick(s.mode[mpc_pkg::DIV2_LSB +: 8], s.bcnt,
                           pre_tick(s.mode[mpc_pkg::PRE2_LSB +: 4], s.pcnt, 1'b0, 1'b0));

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      tick[i] = pre_tick(s.cfg[i][3:0], s.pcnt, tick_a, tick_b);
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] rv;
    logic [1:0]  ch;
    rv = mpc_pkg::RST_WORD;
    ch = s.paddr[6:5];
    next_s = s;
    next_s.rdy = 1'b1;
    next_s.err = 1'b0;
    next_s.pcnt = s.pcnt + 10'h001;
    next_s.acnt = div_next(s.mode[mpc_pkg::DIV1_LSB +: 8], s.acnt,
                           pre_tick(s.mode[mpc_pkg::PRE1_LSB +: 4], s.pcnt, 1'b0, 1'b0));
    next_s.bcnt = div_next(s.mode[mpc_pkg::DIV2_LSB +: 8], s.bcnt,
                           pre_tick(s.mode[mpc_pkg::PRE2_LSB +: 4], s.pcnt, 1'b0, 1'b0));

    // a read of the flag register clears, a same-cycle period end still lands
    if (rd_flags) next_s.flag = '0;

    // channel counters
    for (int i = 0; i < NCH; i++) begin
      if (s.run[i] && tick[i]) begin
        if (!s.cfg[i][mpc_pkg::ALIGN_BIT]) begin
          if ({1'b0, s.cnt[i]} + 17'h00001 >= {1'b0, s.prd[i]}) begin
            next_s.cnt[i] = '0;
            next_s.flag[i] = 1'b1;
          end else begin
            next_s.cnt[i] = s.cnt[i] + 1'b1;
          end
        end else if (!s.dir[i]) begin
          next_s.cnt[i] = s.cnt[i] + 1'b1;
          if ({1'b0, s.cnt[i]} + 17'h00001 >= {1'b0, s.prd[i]}) next_s.dir[i] = 1'b1;
        end else if (s.cnt[i] <= CW'(1)) begin
          next_s.cnt[i] = '0;
          next_s.dir[i] = 1'b0;
          next_s.flag[i] = 1'b1;
        end else begin
          next_s.cnt[i] = s.cnt[i] - 1'b1;
        end
        // buffered value lands at the start of the next period
        if (next_s.flag[i] && !s.flag[i] || next_s.cnt[i] == '0 && !next_s.dir[i]) begin
          if (s.upd_v[i]) begin
            if (s.cfg[i][mpc_pkg::UPD_BIT]) next_s.prd[i] = s.upd[i];
            else next_s.dty[i] = s.upd[i];
            next_s.upd_v[i] = 1'b0;
          end
        end
      end
    end

    // data phase of a write
    if (wr_go) begin
      unique case (s.paddr)
        mpc_pkg::OFS_MODE:    next_s.mode = hwdata;
        mpc_pkg::OFS_START: begin
          for (int i = 0; i < NCH; i++) begin
            if (hwdata[i]) begin
              next_s.run[i] = 1'b1;
              next_s.cnt[i] = '0;
              next_s.dir[i] = 1'b0;
            end
          end
        end
        mpc_pkg::OFS_STOP:    next_s.run  = s.run & ~hwdata[NCH-1:0];
        mpc_pkg::OFS_IRQ_SET: next_s.mask = s.mask | hwdata[NCH-1:0];
        mpc_pkg::OFS_IRQ_CLR: next_s.mask = s.mask & ~hwdata[NCH-1:0];
        default: begin
          if (is_ch(s.paddr)) begin
            unique case (s.paddr[4:0])
              mpc_pkg::OFS_CFG:    next_s.cfg[ch] = {hwdata[10:8], 4'h0, hwdata[3:0]};
              mpc_pkg::OFS_DUTY:   next_s.dty[ch] = hwdata[CW-1:0];
              mpc_pkg::OFS_PERIOD: next_s.prd[ch] = hwdata[CW-1:0];
              mpc_pkg::OFS_UPDATE: begin
                // a stopped channel has no period end to wait for
                if (!s.run[ch]) begin
                  if (s.cfg[ch][mpc_pkg::UPD_BIT]) next_s.prd[ch] = hwdata[CW-1:0];
                  else next_s.dty[ch] = hwdata[CW-1:0];
                end else begin
                  next_s.upd[ch]   = hwdata[CW-1:0];
                  next_s.upd_v[ch] = 1'b1;
                end
              end
              default: ;
            endcase
          end
        end
      endcase
    end

    // waveform levels follow the counter that is about to be registered
    for (int i = 0; i < NCH; i++) begin
      if (!next_s.run[i]) next_s.pwm[i] = 1'b0;
      else if (next_s.cnt[i] < next_s.dty[i])
        next_s.pwm[i] = next_s.cfg[i][mpc_pkg::POL_BIT];
      else next_s.pwm[i] = !next_s.cfg[i][mpc_pkg::POL_BIT];
    end

    // address phase: latch, and prepare read data for the data phase
    next_s.pend = acc;
    next_s.pwr  = acc && hwrite;
    if (acc) next_s.paddr = haddr[9:0];
    if (acc && !hwrite) begin
      unique case (haddr[9:0])
        mpc_pkg::OFS_MODE:  rv = s.mode;
        mpc_pkg::OFS_RUN:   rv[NCH-1:0] = s.run;
        mpc_pkg::OFS_MASK:  rv[NCH-1:0] = s.mask;
        mpc_pkg::OFS_FLAGS: rv[NCH-1:0] = s.flag;
        default: begin
          if (is_ch(haddr[9:0])) begin
            unique case (haddr[4:0])
              mpc_pkg::OFS_CFG:    rv[10:0] = s.cfg[haddr[6:5]];
              mpc_pkg::OFS_DUTY:   rv[CW-1:0] = s.dty[haddr[6:5]];
              mpc_pkg::OFS_PERIOD: rv[CW-1:0] = s.prd[haddr[6:5]];
              mpc_pkg::OFS_COUNT:  rv[CW-1:0] = s.cnt[haddr[6:5]];
              default: ;
            endcase
          end
        end
      endcase
      next_s.rdata = rv;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s     <= '0;
      s.rdy <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = s.rdy;
  assign hresp     = s.err;
  assign hrdata    = s.rdata;
  assign pwm_out   = s.pwm;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_start0;
    wr_go && s.paddr == mpc_pkg::OFS_START && hwdata[0];
  endsequence

  sequence s_upd_armed;
    s.upd_v[0] && s.run[0] && s.cfg[0][mpc_pkg::UPD_BIT];
  endsequence

  a_start_runs: assert property (s_start0 |=> s.run[0] && s.cnt[0] == '0)
    else $error("start did not run channel with cleared counter");
  a_stop_halts: assert property (wr_go && s.paddr == mpc_pkg::OFS_STOP && hwdata[0]
    |=> !s.run[0] && !pwm_out[0])
    else $error("stop did not halt channel");
  a_mask_set: assert property (wr_go && s.paddr == mpc_pkg::OFS_IRQ_SET
    |=> s.mask == ($past(s.mask) | $past(hwdata[NCH-1:0])))
    else $error("mask bit not set");
  a_mask_clear: assert property (wr_go && s.paddr == mpc_pkg::OFS_IRQ_CLR
    |=> s.mask == ($past(s.mask) & ~$past(hwdata[NCH-1:0])))
    else $error("mask bit not cleared");
  a_mask_read: assert property (acc && !hwrite && haddr[9:0] == mpc_pkg::OFS_MASK
    |=> hrdata == 32'($past(s.mask)))
    else $error("mask view wrong");
  a_flags_clear: assert property (rd_flags && (s.run & tick) == '0 |=> s.flag == '0)
    else $error("flag read did not clear");
  a_left_wrap: assert property (s.run[0] && tick[0] && !s.cfg[0][mpc_pkg::ALIGN_BIT]
    && s.prd[0] > CW'(1) && s.cnt[0] == s.prd[0] - 1'b1 && !wr_go |=> s.cnt[0] == '0 && s.flag[0])
    else $error("left aligned counter did not wrap with event");
  a_update_load: assert property (s_upd_armed ##0 (tick[0] && !wr_go
    && !s.cfg[0][mpc_pkg::ALIGN_BIT] && s.cnt[0] == s.prd[0] - CW'(1))
    |=> s.prd[0] == $past(s.upd[0]) && !s.upd_v[0])
    else $error("buffered period not loaded at period end");
  a_level_start: assert property (s.run[0] && s.cnt[0] < s.dty[0]
    |-> pwm_out[0] == s.cfg[0][mpc_pkg::POL_BIT])
    else $error("output not at start level before duty match");
  a_run_view: assert property (acc && !hwrite && haddr[9:0] == mpc_pkg::OFS_RUN
    |=> hrdata[NCH-1:0] == $past(s.run))
    else $error("run status view wrong");

endmodule

`default_nettype wire

// >>> tb/testbench.sv
// testbench for the four-channel pwm controller: registers, waveform timing, event flags
// assumes mpc_top with default parameters and hready looped back from hreadyout
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct { int per; int st; } mpc_meas_t;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [3:0]  pwm_out;
  logic        rd_dp;
  logic        mpol;
  logic        prv;
  int          skip;
  int          n_edges;
  int          since;
  int          run;
  int          err_count;
  int          total_checks;
  integer      seed;
  logic [31:0] exp_q[$];
  mpc_meas_t   mq[$];

  mpc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pwm_out(pwm_out));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [31:0] ga(input logic [9:0] o);
    return {22'h0, o};
  endfunction

  function automatic logic [31:0] ca(input logic [1:0] ch, input logic [4:0] o);
    return {22'h0, mpc_pkg::CH_REGION, ch, o};
  endfunction

  function automatic logic [31:0] cfgw(input logic [3:0] pre, input logic al, input logic pol,
                                       input logic upd);
    return {21'h0, upd, pol, al, 4'h0, pre};
  endfunction

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp  <= !wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp  <= 1'b0;
  endtask

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_reg(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  // stop first: alignment and polarity may only change on a stopped channel
  task automatic meas(input logic [3:0] pre, input logic al, input logic pol, input int dv);
    mpc_meas_t m;
    m.per = al ? 8 * dv : 4 * dv;
    m.st  = al ? 3 * dv : 2 * dv;
    wr_reg(ga(mpc_pkg::OFS_STOP), 32'h1);
    wr_reg(ca(2'h0, mpc_pkg::OFS_CFG), cfgw(pre, al, pol, 1'b0));
    wr_reg(ca(2'h0, mpc_pkg::OFS_DUTY), 32'h2);
    wr_reg(ca(2'h0, mpc_pkg::OFS_PERIOD), 32'h4);
    mpol <= pol;
    skip <= 1;
    wr_reg(ga(mpc_pkg::OFS_START), 32'h1);
    rd_reg(ga(mpc_pkg::OFS_RUN), 32'h1);
    mq.push_back(m);
    mq.push_back(m);
    while (mq.size() != 0) @(posedge hclk);
  endtask

  // ----------------------------------------------------------------
  // monitors: read data and channel 0 waveform
  // ----------------------------------------------------------------
  always @(posedge hclk) begin
    if (rd_dp && hreadyout && exp_q.size() > 0) begin
      check("hrdata", hrdata, exp_q.pop_front());
      check("hresp", {31'h0, hresp}, 32'h0);
    end
  end

  // first edge after a restart spans a partial period, so it is skipped
  always @(posedge hclk) begin
    mpc_meas_t m;
    if (pwm_out[0] !== prv) begin
      if (pwm_out[0] === ~mpol) begin
        n_edges <= n_edges + 1;
        if (skip > 0) skip <= skip - 1;
        else if (mq.size() > 0) begin
          m = mq.pop_front();
          check("period", since, m.per);
          check("start_len", run, m.st);
        end
        since = 0;
      end
      run = 0;
    end
    since++;
    run++;
    prv = pwm_out[0];
  end

  initial begin
    repeat (60000) @(posedge hclk);
    err_count++;
    results();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    seed = 32'h2AD8;
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; rd_dp = 1'b0; mpol = 1'b0; prv = 1'b0;
    skip = 0; n_edges = 0; since = 0; run = 0; err_count = 0; total_checks = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd_reg(ga(mpc_pkg::OFS_RUN), 32'h0);
    rd_reg(ga(mpc_pkg::OFS_MASK), 32'h0);
    rd_reg(ga(mpc_pkg::OFS_FLAGS), 32'h0);
    rd_reg(ca(2'h3, mpc_pkg::OFS_COUNT), 32'h0);
    rd_reg(ga(10'h100), 32'h0);
    $display("test reset_map done");
    r = {28'h0, 4'($random(seed))};
    wr_reg(ga(mpc_pkg::OFS_IRQ_SET), r);
    rd_reg(ga(mpc_pkg::OFS_MASK), r);
    wr_reg(ga(mpc_pkg::OFS_IRQ_CLR), r & 32'h5);
    rd_reg(ga(mpc_pkg::OFS_MASK), r & 32'hA);
    wr_reg(ga(mpc_pkg::OFS_IRQ_SET), 32'h0);
    rd_reg(ga(mpc_pkg::OFS_MASK), r & 32'hA);
    $display("test irq_mask done");
    for (int ch = 1; ch < 4; ch++) begin
      r = $random(seed);
      wr_reg(ca(2'(ch), mpc_pkg::OFS_DUTY), r);
      rd_reg(ca(2'(ch), mpc_pkg::OFS_DUTY), {16'h0, r[15:0]});
    end
    wr_reg(ca(2'h1, mpc_pkg::OFS_CFG), 32'hFFFF_FFFF);
    rd_reg(ca(2'h1, mpc_pkg::OFS_CFG), 32'h0000_070F);
    $display("test reg_width done");
    for (int k = 0; k <= 10; k++)
      meas(4'(k), 1'b0, 1'b0, 1 << k);
    meas(4'h1, 1'b1, 1'b1, 2);
    wr_reg(ga(mpc_pkg::OFS_MODE), 32'h0005_0103);
    rd_reg(ga(mpc_pkg::OFS_MODE), 32'h0005_0103);
    meas(mpc_pkg::PRE_DIV1, 1'b0, 1'b1, 6);
    meas(mpc_pkg::PRE_DIV2, 1'b1, 1'b0, 5);
    $display("test waveform done");
    wr_reg(ga(mpc_pkg::OFS_STOP), 32'h1);
    wr_reg(ga(mpc_pkg::OFS_MODE), 32'h0000_0103);
    wr_reg(ca(2'h0, mpc_pkg::OFS_CFG), cfgw(mpc_pkg::PRE_DIV2, 1'b0, 1'b0, 1'b0));
    wr_reg(ga(mpc_pkg::OFS_START), 32'h1);
    rd_reg(ca(2'h0, mpc_pkg::OFS_COUNT), 32'h0);
    rd_reg(ca(2'h0, mpc_pkg::OFS_COUNT), 32'h0);
    $display("test count_clear done");
    meas(4'h6, 1'b0, 1'b0, 64);
    wr_reg(ca(2'h0, mpc_pkg::OFS_CFG), cfgw(4'h6, 1'b0, 1'b0, 1'b1));
    r = n_edges;
    while (n_edges == r) @(posedge hclk);
    // just past the duty point: two ticks remain before the period ends
    wr_reg(ca(2'h0, mpc_pkg::OFS_UPDATE), 32'h6);
    rd_reg(ca(2'h0, mpc_pkg::OFS_PERIOD), 32'h4);
    skip <= 2;
    mq.push_back('{6 * 64, 2 * 64});
    while (mq.size() != 0) @(posedge hclk);
    rd_reg(ca(2'h0, mpc_pkg::OFS_PERIOD), 32'h6);
    $display("test update done");
    wr_reg(ga(mpc_pkg::OFS_STOP), 32'h1);
    rd_reg(ga(mpc_pkg::OFS_RUN), 32'h0);
    check("pwm_out", {28'h0, pwm_out}, 32'h0);
    rd_reg(ga(mpc_pkg::OFS_FLAGS), 32'h1);
    rd_reg(ga(mpc_pkg::OFS_FLAGS), 32'h0);
    repeat (2) @(posedge hclk);
    $display("test flags done");
    results();
  end
endmodule
`default_nettype wire
